/* File: verilog/abwm_write_slave.sv */
// AXI burst write slave of the memory subsystem with a skid buffer toward memory
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Fabric clock at half memory clock preferred
// - Reference: 166 MHz memory, 83 MHz fabric
// - Fabric port carries 64-bit data beats
// - Memory burst length four, eight or sixteen
// - Accept bursts up to sixteen beats only
// - Sixteen beat bursts give best throughput
// - Response valid after all beats accepted
module abwm_write_slave import abwm_pkg::*; (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // Clock and memory configuration straps
    input wire logic [3:0] clk_ratio_i,
    input wire logic [1:0] mem_bl_sel_i,
    output logic cfg_ratio_opt_o,
    output logic cfg_optimal_o,
    // Write address channel
    input wire logic [3:0] awid_i,
    input wire logic [ADDR_W-1:0] awaddr_i,
    input wire logic [7:0] awlen_i,
    input wire logic [2:0] awsize_i,
    input wire logic awvalid_i,
    output logic awready_o,
    // Write data channel
    input wire logic [DATA_W-1:0] wdata_i,
    input wire logic [STRB_W-1:0] wstrb_i,
    input wire logic wlast_i,
    input wire logic wvalid_i,
    output logic wready_o,
    // Write response channel
    output logic [3:0] bid_o,
    output logic [1:0] bresp_o,
    output logic bvalid_o,
    input wire logic bready_i,
    // Beat stream toward the memory controller
    output logic mem_wvalid_o,
    output logic [ADDR_W-1:0] mem_waddr_o,
    output logic [DATA_W-1:0] mem_wdata_o,
    output logic [STRB_W-1:0] mem_wstrb_o,
    output logic mem_bst_end_o,
    input wire logic mem_wready_i
);
    abwm_state_t state_q, state_d; // Slave sequencing
    logic [3:0] id_q; // Captured transaction id
    logic [ADDR_W-1:0] addr_q; // Address of the next beat
    logic [7:0] len_q; // Beats minus one
    logic [7:0] beat_q; // Beats taken so far
    logic err_q; // Burst refused, no memory writes
    logic awready_q, wready_q, bvalid_q; // Handshake flops
    logic [1:0] bresp_q;
    logic ratio_opt_q, optimal_q; // Configuration status
    logic out_valid_q, skid_valid_q; // Two-entry buffer occupancy
    logic [BEAT_W-1:0] out_q, skid_q; // Output stage and skid stage

    // Channel handshakes
    wire aw_fire = awvalid_i && awready_q;
    wire w_fire = wvalid_i && wready_q;
    wire b_fire = bvalid_q && bready_i;
    wire last_beat = w_fire && (beat_q == len_q);
    // Refuse long bursts and narrow beats
    wire aw_bad = (awlen_i > MAX_LEN) || (awsize_i != SIZE_64);
    // Memory burst chunk end by selected length
    wire [7:0] bl_mask = (mem_bl_sel_i == BL_SEL_4) ? 8'h03 :
                         (mem_bl_sel_i == BL_SEL_8) ? 8'h07 : 8'h0F;
    wire chunk_end = ((beat_q & bl_mask) == bl_mask) || (beat_q == len_q);
    // Beats of a refused burst are swallowed but never written
    wire push = w_fire && !err_q;
    wire [BEAT_W-1:0] in_beat = {addr_q, wdata_i, wstrb_i, chunk_end};

    // Skid buffer steering: output stage reloads when empty or drained
    wire out_free = !out_valid_q || mem_wready_i;
    wire out_valid_d = out_free ? (skid_valid_q || push) : 1'b1;
    wire [BEAT_W-1:0] out_d = !out_free ? out_q : (skid_valid_q ? skid_q : in_beat);
    wire skid_valid_d = out_free ? (skid_valid_q && push) : (skid_valid_q || push);
    wire [BEAT_W-1:0] skid_d = push ? in_beat : skid_q;

    // Next state of the burst sequence
    always_comb begin
        state_d = state_q;
        case (state_q)
            ABWM_ADDR: begin
                if (aw_fire) begin
                    state_d = ABWM_DATA;
                end
            end
            ABWM_DATA: begin
                if (last_beat) begin
                    state_d = ABWM_RESP;
                end
            end
            ABWM_RESP: begin
                if (b_fire) begin
                    state_d = ABWM_ADDR;
                end
            end
            default: begin
                state_d = ABWM_ADDR;
            end
        endcase
    end

    // Ready flags follow next state, so outputs come from flops.
    // Data ready also drops while the skid is full: memory stall back-pressures the master.
    wire awready_d = (state_d == ABWM_ADDR);
    wire wready_d = (state_d == ABWM_DATA) && !skid_valid_d;

    // Sequence and handshake flops
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            state_q <= ABWM_ADDR;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            bvalid_q <= 1'b0;
        end else begin
            state_q <= state_d;
            awready_q <= awready_d;
            wready_q <= wready_d;
            bvalid_q <= (state_d == ABWM_RESP);
        end
    end

    // Burst context capture and beat tracking
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            id_q <= 4'h0;
            addr_q <= '0;
            len_q <= 8'h00;
            beat_q <= 8'h00;
            err_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else if (aw_fire) begin
            id_q <= awid_i;
            addr_q <= awaddr_i;
            len_q <= awlen_i;
            beat_q <= 8'h00;
            err_q <= aw_bad;
            bresp_q <= aw_bad ? RESP_SLVERR : RESP_OKAY;
        end else if (w_fire) begin
            addr_q <= addr_q + BEAT_BYTES;
            beat_q <= beat_q + 8'h01;
            // Early or missing last marker spoils the burst
            if (wlast_i != (beat_q == len_q)) begin
                bresp_q <= RESP_SLVERR;
            end
        end
    end

    // Two-entry buffer stages toward memory
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            out_valid_q <= 1'b0;
            skid_valid_q <= 1'b0;
            out_q <= '0;
            skid_q <= '0;
        end else begin
            out_valid_q <= out_valid_d;
            skid_valid_q <= skid_valid_d;
            out_q <= out_d;
            skid_q <= skid_d;
        end
    end

    // Configuration status: half-rate fabric clock and sixteen beat memory bursts
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            ratio_opt_q <= 1'b0;
            optimal_q <= 1'b0;
        end else begin
            ratio_opt_q <= (clk_ratio_i == RATIO_OPT);
            optimal_q <= (clk_ratio_i == RATIO_OPT) && (mem_bl_sel_i == BL_SEL_16);
        end
    end

    // Port drive, all from flops
    assign awready_o = awready_q;
    assign wready_o = wready_q;
    assign bvalid_o = bvalid_q;
    assign bid_o = id_q;
    assign bresp_o = bresp_q;
    assign mem_wvalid_o = out_valid_q;
    assign {mem_waddr_o, mem_wdata_o, mem_wstrb_o, mem_bst_end_o} = out_q;
    assign cfg_ratio_opt_o = ratio_opt_q;
    assign cfg_optimal_o = optimal_q;

    // Checks on the slave behaviour
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    ratio_status_a: assert property (clk_ratio_i == RATIO_OPT |=> cfg_ratio_opt_o)
        else $error("ratio status not raised for half-rate clock");
    optimal_cfg_a: assert property ((clk_ratio_i == RATIO_OPT && mem_bl_sel_i == BL_SEL_16)
        |=> cfg_optimal_o)
        else $error("optimal configuration not reported");
    narrow_refused_a: assert property (aw_fire && awsize_i != SIZE_64 |=> err_q)
        else $error("narrow beat size not refused");
    chunk_end_a: assert property (push && mem_bl_sel_i == BL_SEL_4 && beat_q[1:0] == 2'h3
        |-> in_beat[0])
        else $error("memory burst chunk end missing");
    long_refused_a: assert property (aw_fire && awlen_i > MAX_LEN
        |=> ##[0:300] (bvalid_o && bresp_o == RESP_SLVERR))
        else $error("over-long burst not answered with error");
    sixteen_ok_a: assert property (cfg_optimal_o |-> $past(mem_bl_sel_i) == BL_SEL_16)
        else $error("optimal flag without sixteen beat bursts");
    resp_after_last_a: assert property (last_beat |=> bvalid_o && !wready_o && !awready_o)
        else $error("response not raised after last beat");
    resp_hold_a: assert property (bvalid_o && !bready_i |=> bvalid_o && $stable(bresp_o))
        else $error("response dropped before acceptance");

    ok_burst_c: cover property (last_beat && !err_q ##[1:4] b_fire && bresp_o == RESP_OKAY);
    err_burst_c: cover property (b_fire && bresp_o == RESP_SLVERR);
    skid_full_c: cover property (skid_valid_q && out_valid_q && !mem_wready_i);
endmodule

`default_nettype wire

/* File: verilog/abwm_pkg.sv */
// Shared constants for the burst write slave port of the memory subsystem
package abwm_pkg;
    // Clocking relation of memory clock to fabric interface clock
    localparam int DDR_CLK_MHZ = 166; // Memory clock in reference setup
    localparam int AXI_CLK_MHZ = 83; // Fabric interface clock in reference setup
    localparam logic [3:0] RATIO_OPT = 4'h2; // Best throughput divider ratio
    // Bus shape
    localparam int DATA_W = 64; // Fabric data bus width
    localparam int STRB_W = DATA_W / 8; // Byte strobes
    localparam int ADDR_W = 32; // Byte address width
    localparam logic [2:0] SIZE_64 = 3'h3; // Eight bytes per beat
    localparam logic [7:0] MAX_LEN = 8'h0F; // Sixteen beats, len minus one
    localparam logic [ADDR_W-1:0] BEAT_BYTES = 32'h0000_0008; // Address step per beat
    // Write response codes
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Memory side burst length select
    localparam logic [1:0] BL_SEL_4 = 2'h0;
    localparam logic [1:0] BL_SEL_8 = 2'h1;
    localparam logic [1:0] BL_SEL_16 = 2'h2;
    // Beat record carried through the two-entry buffer
    localparam int BEAT_W = ADDR_W + DATA_W + STRB_W + 1;
    // Slave states
    typedef enum logic [1:0] {ABWM_ADDR, ABWM_DATA, ABWM_RESP} abwm_state_t;
endpackage

/* File: sim/abwm_master_model.sv */
// Behavioural AXI burst write master facing the slave port
`timescale 1ns/1ps
`default_nettype none
module abwm_master_model import abwm_pkg::*; (
    input wire logic clk_i,
    input wire logic start_i,
    input wire logic [3:0] nb_i,
    input wire logic bad_len_i,
    input wire logic bad_last_i,
    input wire logic pipe_i,
    input wire logic awready_i,
    input wire logic wready_i,
    input wire logic [1:0] bresp_i,
    input wire logic bvalid_i,
    output logic [ADDR_W-1:0] awaddr_o,
    output logic [7:0] awlen_o,
    output logic awvalid_o,
    output logic [DATA_W-1:0] wdata_o,
    output logic wlast_o,
    output logic wvalid_o,
    output logic bready_o,
    output logic done_o,
    output logic [7:0] nresp_o,
    output logic [7:0] nerr_o
);
    logic [31:0] a; // Beat address, also folded into data
    // Pipelined writer: next address right after last beat
    initial begin
        {awaddr_o, awlen_o, awvalid_o, wdata_o, wlast_o, wvalid_o, done_o} = '0;
        forever begin
            @(posedge start_i);
            done_o = 0;
            for (int b = 0; b < nb_i; b++) begin
                // Conventional mode holds the next address until all earlier answers are in
                while (!pipe_i && nresp_o < 8'(b)) @(posedge clk_i);
                #1;
                awaddr_o = 32'(b * 128);
                awlen_o = bad_len_i ? 8'h10 : MAX_LEN;
                awvalid_o = 1;
                // Ready is registered, so negedge sampling is race free
                do @(negedge clk_i); while (!awready_i);
                @(posedge clk_i);
                #1 awvalid_o = 0;
                for (int n = 0; n <= awlen_o; n++) begin
                    a = awaddr_o + 32'(n * 8);
                    wdata_o = {a, ~a};
                    wlast_o = (n == awlen_o) ^ bad_last_i;
                    wvalid_o = 1;
                    do @(negedge clk_i); while (!wready_i);
                    @(posedge clk_i);
                    #1;
                end
                wvalid_o = 0;
                wlast_o = 0;
            end
            // Sequence ends only once every burst is answered
            while (nresp_o < 8'(nb_i)) @(posedge clk_i);
            done_o = 1;
        end
    end
    // Response watch runs beside new bursts; ready toggles at random
    always @(posedge clk_i) begin
        if (start_i) begin
            nresp_o <= 0;
            nerr_o <= 0;
        end else if (bvalid_i && bready_o) begin
            nresp_o <= nresp_o + 1;
            if (bresp_i !== RESP_OKAY) nerr_o <= nerr_o + 1;
        end
        bready_o <= #1 1'($urandom % 2);
    end
endmodule
`default_nettype wire

/* File: sim/tb.sv */
// Self-checking bench for the burst write slave port
`timescale 1ns/1ps
`default_nettype none
module tb import abwm_pkg::*;;
    logic sys_clk_i = 0, rst_i = 1, start = 0, bad_len = 0, bad_last = 0;
    logic mem_wready_i = 0, pipe = 1;
    logic [2:0] awsize = SIZE_64;
    logic [3:0] clk_ratio_i = 0, nb = 0;
    logic [1:0] mem_bl_sel_i = 0;
    wire logic ropt, opt, awvalid, awready, wlast, wvalid, wready, bvalid, bready, done;
    wire logic mem_wvalid_o, mem_bst_end_o;
    wire logic [1:0] bresp;
    wire logic [3:0] bid;
    wire logic [7:0] awlen, nresp, nerr, mem_wstrb_o;
    wire logic [31:0] awaddr, mem_waddr_o;
    wire logic [63:0] wdata, mem_wdata_o;
    logic [96:0] exp_q[$]; // Address, data, burst end per beat
    int num_errors = 0, num_checks = 0, cyc = 0;
    always #20 sys_clk_i = ~sys_clk_i;
    abwm_write_slave dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .clk_ratio_i(clk_ratio_i),
        .mem_bl_sel_i(mem_bl_sel_i), .cfg_ratio_opt_o(ropt), .cfg_optimal_o(opt),
        .awid_i(4'h5), .awaddr_i(awaddr), .awlen_i(awlen), .awsize_i(awsize),
        .awvalid_i(awvalid), .awready_o(awready), .wdata_i(wdata), .wstrb_i(8'hFF),
        .wlast_i(wlast), .wvalid_i(wvalid), .wready_o(wready), .bid_o(bid), .bresp_o(bresp),
        .bvalid_o(bvalid), .bready_i(bready), .mem_wvalid_o(mem_wvalid_o),
        .mem_waddr_o(mem_waddr_o), .mem_wdata_o(mem_wdata_o), .mem_wstrb_o(mem_wstrb_o),
        .mem_bst_end_o(mem_bst_end_o), .mem_wready_i(mem_wready_i));
    abwm_master_model mst (.clk_i(sys_clk_i), .start_i(start), .nb_i(nb), .bad_len_i(bad_len),
        .bad_last_i(bad_last), .pipe_i(pipe), .awready_i(awready), .wready_i(wready),
        .bresp_i(bresp),
        .bvalid_i(bvalid), .awaddr_o(awaddr), .awlen_o(awlen), .awvalid_o(awvalid),
        .wdata_o(wdata), .wlast_o(wlast), .wvalid_o(wvalid), .bready_o(bready),
        .done_o(done), .nresp_o(nresp), .nerr_o(nerr));
    task automatic chk(string nm, logic [96:0] seen, logic [96:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Memory side stalls at random; each accepted beat meets the oldest note
    always @(posedge sys_clk_i) begin
        cyc <= cyc + 1;
        if (mem_wvalid_o && mem_wready_i) begin
            if (exp_q.size() == 0) chk("stray beat", 97'h1, 97'h0);
            else chk("beat", {mem_waddr_o, mem_wdata_o, mem_bst_end_o}, exp_q.pop_front());
            chk("strobe", 97'(mem_wstrb_o), 97'hFF);
        end
        // Every answer carries the id of its burst
        if (bvalid && bready) chk("bid", 97'(bid), 97'h5);
        mem_wready_i <= #1 1'($urandom % 4 != 0);
        if (cyc == 20000) begin
            num_errors++;
            conclude();
        end
    end
    // One write sequence; faulty ones expect a single error, refused ones also no beat notes
    task automatic run(input logic [3:0] n, input logic [1:0] bl, input logic bln, input logic blt);
        logic [31:0] a;
        logic [3:0] m;
        mem_bl_sel_i = bl;
        nb = n;
        bad_len = bln;
        bad_last = blt;
        m = (bl == BL_SEL_4) ? 4'h3 : (bl == BL_SEL_8) ? 4'h7 : 4'hF;
        // Refused bursts reach memory with nothing; a bad last marker still writes
        for (int b = 0; b < n && !bln && awsize == SIZE_64; b++)
            for (int k = 0; k < 16; k++) begin
                a = 32'(b * 128 + k * 8);
                exp_q.push_back({a, a, ~a, (4'(k) & m) == m || k == 15});
            end
        start = 1;
        @(posedge sys_clk_i);
        #1 start = 0;
        while (!done) @(posedge sys_clk_i);
        repeat (20) @(posedge sys_clk_i);
        #1;
        chk("responses", 97'(nresp), 97'(n));
        chk("errors", 97'(nerr), (bln | blt | (awsize != SIZE_64)) ? 97'h1 : 97'h0);
        chk("drained", 97'(exp_q.size()), 97'h0);
    endtask
    initial begin
        void'($urandom(32'h1f0d));
        repeat (8) @(posedge sys_clk_i);
        #1 rst_i = 0;
        // Every strap combination, outputs one cycle late
        for (int r = 0; r < 16; r++)
            for (int s = 0; s < 4; s++) begin
                clk_ratio_i = 4'(r);
                mem_bl_sel_i = 2'(s);
                repeat (2) @(posedge sys_clk_i);
                #1;
                chk("ratio", 97'(ropt), 97'(r == 2));
                chk("optimal", 97'(opt), 97'(r == 2 && s == 2));
            end
        clk_ratio_i = 4'h2;
        for (int s = 0; s < 3; s++) run(4'h3, 2'(s), 0, 0);
        run(4'h1, BL_SEL_16, 1, 0);
        run(4'h1, BL_SEL_16, 0, 1);
        run(4'h2, BL_SEL_16, 0, 0);
        // Conventional master, then a narrow beat size that must be refused
        pipe = 0;
        run(4'h2, BL_SEL_8, 0, 0);
        pipe = 1;
        awsize = 3'h2;
        run(4'h1, BL_SEL_16, 0, 0);
        awsize = SIZE_64;
        conclude();
    end
endmodule
`default_nettype wire
